// file: include/cpu_bus_pkg.sv
package cpu_bus_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: 250 MHz system clock, 2 MHz basic bus clock
  localparam int CLK_NS = 4;
  localparam int PHI_NS = 500;
  localparam int PHI_CYCLES = PHI_NS / CLK_NS;
  localparam int PHI_HIGH = PHI_CYCLES / 2;
  localparam logic [6:0] PHI_LAST = 7'(PHI_CYCLES - 1);
  localparam logic [6:0] PHI_HIGH_CNT = 7'(PHI_HIGH);
  // Index of the last basic clock period in a short / long cycle
  localparam logic [2:0] SHORT_LAST = 3'h3;
  localparam logic [2:0] LONG_LAST = 3'h5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and sizes
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] PORT_RESET = 8'hFF;
  localparam logic [3:0] DIRECT_REGS = 4'hC;
  localparam logic [7:0] LOCAL_PORTS = 8'h02;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle command codes
  localparam logic [4:0] CMD_FETCH = 5'h00;
  localparam logic [4:0] CMD_OPERAND = 5'h01;
  localparam logic [4:0] CMD_MEM_READ = 5'h02;
  localparam logic [4:0] CMD_IO_ADDR = 5'h03;
  localparam logic [4:0] CMD_IO_READ = 5'h04;
  localparam logic [4:0] CMD_IO_WRITE = 5'h05;
  localparam logic [4:0] CMD_PC_ADD = 5'h06;
  localparam logic [4:0] CMD_VEC_LO = 5'h07;
  localparam logic [4:0] CMD_VEC_HI = 5'h08;
  localparam logic [4:0] CMD_IDLE = 5'h1F;

  ////////////////////////////////////////////////////////////////////////////
  // Opcode groups (upper nibble) and two-byte sub-operations (lower nibble)
  localparam logic [3:0] OP_STORE = 4'h0;
  localparam logic [3:0] OP_LOAD = 4'h1;
  localparam logic [3:0] OP_ADD = 4'h2;
  localparam logic [3:0] OP_AND = 4'h3;
  localparam logic [3:0] OP_XOR = 4'h4;
  localparam logic [3:0] OP_LONG = 4'h5;
  localparam logic [3:0] OP_IN = 4'h6;
  localparam logic [3:0] OP_OUT = 4'h7;
  localparam logic [3:0] OP_INT_EN = 4'h8;
  localparam logic [3:0] SUB_CMP_IMM = 4'h3;
  localparam logic [3:0] SUB_ADD_MEM = 4'h4;
  localparam logic [3:0] SUB_XOR_MEM = 4'h6;
  localparam logic [3:0] SUB_LOAD_IMM = 4'h7;
  localparam logic [3:0] SUB_IN_LONG = 4'h8;
  localparam logic [3:0] SUB_OUT_LONG = 4'h9;
  localparam logic [3:0] SUB_BR_ZERO = 4'hA;
  localparam logic [3:0] SUB_BR_NZERO = 4'hB;

  // ALU selections: add, and, xor, pass operand
  localparam logic [1:0] ALU_ADD = 2'h0;
  localparam logic [1:0] ALU_AND = 2'h1;
  localparam logic [1:0] ALU_XOR = 2'h2;
  localparam logic [1:0] ALU_PASS = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [3:0] {
    ST_FETCH = 4'h0,
    ST_OPERAND = 4'h1,
    ST_MEM = 4'h3,
    ST_BRANCH = 4'h2,
    ST_IO_ADDR = 4'h6,
    ST_IO_DATA = 4'h7,
    ST_EXEC = 4'h5,
    ST_VEC_LO = 4'h4,
    ST_VEC_HI = 4'hC
  } seq_state_e;

  typedef struct packed {
    logic [1:0][7:0] o;
    logic [1:0][7:0] oe;
  } port_pins_s;

  typedef struct packed {
    logic [6:0] cnt;
    logic [2:0] idx;
    logic lng;
    logic phi;
    logic strobe;
  } strobe_state_s;

endpackage

// file: hdl/strobe_gen.sv
`timescale 1ns/1ps
`default_nettype none

// Basic bus clock divider and cycle strobe generator
module strobe_gen (
  input wire logic clock,
  input wire logic resetn,
  input wire logic long_next,
  output logic phi,
  output logic write_strobe,
  output logic cycle_end
);

  cpu_bus_pkg::strobe_state_s s_r, s_nxt;
  logic tick;

  ////////////////////////////////////////////////////////////////////////////
  // One basic clock period is PHI_CYCLES system clocks; the strobe is high
  // for the last period of each 4- or 6-period cycle
  always_comb begin
    s_nxt = s_r;
    tick = (s_r.cnt == cpu_bus_pkg::PHI_LAST);
    s_nxt.cnt = tick ? 7'h00 : s_r.cnt + 7'h01;
    s_nxt.phi = (s_nxt.cnt < cpu_bus_pkg::PHI_HIGH_CNT);
    if (tick) begin
      if (s_r.strobe) begin
        s_nxt.idx = 3'h0;
        s_nxt.lng = long_next; // Length is fixed for the whole cycle
      end else begin
        s_nxt.idx = s_r.idx + 3'h1;
      end
    end
    s_nxt.strobe = (s_nxt.idx == (s_nxt.lng ? cpu_bus_pkg::LONG_LAST :
                                  cpu_bus_pkg::SHORT_LAST));
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{cnt: 7'h00, idx: 3'h0, lng: 1'b0, phi: 1'b1, strobe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Trailing edge of the strobe closes the instruction cycle
  assign cycle_end = tick && s_r.strobe;
  assign phi = s_r.phi;
  assign write_strobe = s_r.strobe;

endmodule

`default_nettype wire

// file: hdl/scratch_ram.sv
`timescale 1ns/1ps
`default_nettype none

// Static scratchpad, 64 bytes, registered read data
module scratch_ram (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [5:0] addr,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);

  typedef struct packed {
    logic [63:0][7:0] mem;
    logic [7:0] rd;
  } ram_state_s;

  ram_state_s s_r, s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Read is always registered so the value is stable a cycle later
  always_comb begin
    s_nxt = s_r;
    s_nxt.rd = s_r.mem[addr];
    if (wr_en) begin
      s_nxt.mem[addr] = wr_data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data = s_r.rd;

endmodule

`default_nettype wire

// file: hdl/cpu_bus_sequencer.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_sequencer (
  input wire logic clock,
  input wire logic resetn,
  output logic phi,
  output logic write_strobe,
  output logic [4:0] cycle_command_code,
  input wire logic [7:0] shared_data_lines_i,
  output logic [7:0] shared_data_lines_o,
  output logic [7:0] shared_data_lines_oe,
  input wire logic int_req_n,
  input wire logic [1:0][7:0] port_i,
  output cpu_bus_pkg::port_pins_s port_pins,
  output logic [15:0] program_counter,
  output logic [7:0] accumulator,
  output logic zero_flag
);

  typedef struct packed {
    cpu_bus_pkg::seq_state_e st;
    logic [4:0] cmd;
    logic [15:0] pc;
    logic [7:0] acc;
    logic zero;
    logic int_en;
    logic [7:0] instr;
    logic [7:0] imm;
    logic [7:0] port;
    logic is_out;
    logic [7:0] dbo;
    logic dboe;
    logic [1:0][7:0] latch;
    logic [7:0] db_s1;
    logic [7:0] db_s2;
    logic int_s1;
    logic int_s2;
    logic [1:0][7:0] pt_s1;
    logic [1:0][7:0] pt_s2;
  } seq_s;

  seq_s s_r, s_nxt;
  logic cycle_end;
  logic long_next;
  logic [7:0] scratch_rd;
  logic scratch_we;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Accumulator-centred ALU: result only ever lands in the accumulator
  function automatic logic [7:0] alu(input logic [1:0] sel,
                                     input logic [7:0] a,
                                     input logic [7:0] b);
    logic [7:0] r;
    r = b;
    unique case (sel)
      cpu_bus_pkg::ALU_ADD: r = a + b;
      cpu_bus_pkg::ALU_AND: r = a & b;
      cpu_bus_pkg::ALU_XOR: r = a ^ b;
      cpu_bus_pkg::ALU_PASS: r = b;
    endcase
    return r;
  endfunction

  // Long cycles give other chips time for inter-chip transfers
  function automatic logic is_long(input cpu_bus_pkg::seq_state_e st);
    return (st == cpu_bus_pkg::ST_IO_ADDR) ||
           (st == cpu_bus_pkg::ST_IO_DATA);
  endfunction

  // Command that announces a given cycle to the other chips
  function automatic logic [4:0] cmd_of(input cpu_bus_pkg::seq_state_e st,
                                        input logic is_out);
    logic [4:0] c;
    c = cpu_bus_pkg::CMD_IDLE;
    unique case (st)
      cpu_bus_pkg::ST_FETCH: c = cpu_bus_pkg::CMD_FETCH;
      cpu_bus_pkg::ST_OPERAND: c = cpu_bus_pkg::CMD_OPERAND;
      cpu_bus_pkg::ST_MEM: c = cpu_bus_pkg::CMD_MEM_READ;
      cpu_bus_pkg::ST_IO_ADDR: c = cpu_bus_pkg::CMD_IO_ADDR;
      cpu_bus_pkg::ST_IO_DATA: c = is_out ? cpu_bus_pkg::CMD_IO_WRITE
                                          : cpu_bus_pkg::CMD_IO_READ;
      cpu_bus_pkg::ST_BRANCH: c = cpu_bus_pkg::CMD_PC_ADD;
      cpu_bus_pkg::ST_VEC_LO: c = cpu_bus_pkg::CMD_VEC_LO;
      cpu_bus_pkg::ST_VEC_HI: c = cpu_bus_pkg::CMD_VEC_HI;
      default: c = cpu_bus_pkg::CMD_IDLE;
    endcase
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Cycle timing and scratchpad

  strobe_gen u_strobe (
    .clock(clock),
    .resetn(resetn),
    .long_next(long_next),
    .phi(phi),
    .write_strobe(write_strobe),
    .cycle_end(cycle_end)
  );

  // Only the twelve directly addressed registers are reachable
  assign scratch_we = cycle_end && (s_r.st == cpu_bus_pkg::ST_EXEC) &&
                      (s_r.instr[7:4] == cpu_bus_pkg::OP_STORE) &&
                      (s_r.instr[3:0] < cpu_bus_pkg::DIRECT_REGS);

  scratch_ram u_scratch (
    .clock(clock),
    .resetn(resetn),
    .addr({2'b00, s_r.instr[3:0]}),
    .wr_en(scratch_we),
    .wr_data(s_r.acc),
    .rd_data(scratch_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: pins are synchronised every clock, architectural state only
  // changes on the last clock of the active strobe
  always_comb begin
    logic [7:0] bus;
    logic [3:0] hi;
    logic [3:0] lo;
    logic [1:0] sel;
    logic [7:0] res;
    logic done;
    logic local_port;
    bus = s_r.db_s2;
    hi = s_r.instr[7:4];
    lo = s_r.instr[3:0];
    sel = cpu_bus_pkg::ALU_PASS;
    res = 8'h00;
    done = 1'b0;
    local_port = (s_r.port < cpu_bus_pkg::LOCAL_PORTS);
    s_nxt = s_r;
    // Two-flop synchronisers for everything arriving from pins
    s_nxt.db_s1 = shared_data_lines_i;
    s_nxt.db_s2 = s_r.db_s1;
    s_nxt.int_s1 = ~int_req_n;
    s_nxt.int_s2 = s_r.int_s1;
    s_nxt.pt_s1 = port_i;
    s_nxt.pt_s2 = s_r.pt_s1;
    if (cycle_end) begin
      unique case (s_r.st)
        cpu_bus_pkg::ST_FETCH: begin
          // Decode of the fetched byte picks the next cycle
          s_nxt.instr = bus;
          s_nxt.pc = s_r.pc + 16'h0001;
          unique case (bus[7:4])
            cpu_bus_pkg::OP_STORE, cpu_bus_pkg::OP_LOAD,
            cpu_bus_pkg::OP_ADD, cpu_bus_pkg::OP_AND,
            cpu_bus_pkg::OP_XOR: s_nxt.st = cpu_bus_pkg::ST_EXEC;
            cpu_bus_pkg::OP_LONG: s_nxt.st = cpu_bus_pkg::ST_OPERAND;
            cpu_bus_pkg::OP_IN, cpu_bus_pkg::OP_OUT: begin
              s_nxt.port = {4'h0, bus[3:0]};
              s_nxt.is_out = (bus[7:4] == cpu_bus_pkg::OP_OUT);
              s_nxt.st = cpu_bus_pkg::ST_IO_ADDR;
            end
            cpu_bus_pkg::OP_INT_EN: begin
              s_nxt.int_en = bus[0];
              done = 1'b1;
            end
            default: done = 1'b1;
          endcase
        end
        cpu_bus_pkg::ST_EXEC: begin
          // Scratchpad operand; registers 12..15 act as no operation
          unique case (hi)
            cpu_bus_pkg::OP_ADD: sel = cpu_bus_pkg::ALU_ADD;
            cpu_bus_pkg::OP_AND: sel = cpu_bus_pkg::ALU_AND;
            cpu_bus_pkg::OP_XOR: sel = cpu_bus_pkg::ALU_XOR;
            default: sel = cpu_bus_pkg::ALU_PASS;
          endcase
          res = alu(sel, s_r.acc, scratch_rd);
          if (hi != cpu_bus_pkg::OP_STORE &&
              lo < cpu_bus_pkg::DIRECT_REGS) begin
            s_nxt.acc = res;
            s_nxt.zero = (res == 8'h00);
          end
          done = 1'b1;
        end
        cpu_bus_pkg::ST_OPERAND: begin
          s_nxt.imm = bus;
          s_nxt.pc = s_r.pc + 16'h0001;
          res = alu(lo[1:0], s_r.acc, bus);
          done = 1'b1;
          if (lo == cpu_bus_pkg::SUB_CMP_IMM) begin
            s_nxt.zero = (bus == s_r.acc);
          end else if (lo < cpu_bus_pkg::SUB_ADD_MEM ||
                       lo == cpu_bus_pkg::SUB_LOAD_IMM) begin
            s_nxt.acc = res;
            s_nxt.zero = (res == 8'h00);
          end else if (lo <= cpu_bus_pkg::SUB_XOR_MEM) begin
            s_nxt.st = cpu_bus_pkg::ST_MEM;
            done = 1'b0;
          end else if (lo == cpu_bus_pkg::SUB_IN_LONG ||
                       lo == cpu_bus_pkg::SUB_OUT_LONG) begin
            s_nxt.port = bus;
            s_nxt.is_out = (lo == cpu_bus_pkg::SUB_OUT_LONG);
            s_nxt.st = cpu_bus_pkg::ST_IO_ADDR;
            done = 1'b0;
          end else if ((lo == cpu_bus_pkg::SUB_BR_ZERO && s_r.zero) ||
                       (lo == cpu_bus_pkg::SUB_BR_NZERO && !s_r.zero)) begin
            s_nxt.st = cpu_bus_pkg::ST_BRANCH;
            done = 1'b0;
          end
        end
        cpu_bus_pkg::ST_MEM: begin
          res = alu(lo[1:0], s_r.acc, bus);
          s_nxt.acc = res;
          s_nxt.zero = (res == 8'h00);
          done = 1'b1;
        end
        cpu_bus_pkg::ST_IO_ADDR: s_nxt.st = cpu_bus_pkg::ST_IO_DATA;
        cpu_bus_pkg::ST_IO_DATA: begin
          // Ports 00 and 01 live here; any other address is a bus chip
          if (s_r.is_out) begin
            if (local_port) begin
              s_nxt.latch[s_r.port[0]] = s_r.acc;
            end
          end else begin
            res = local_port ? s_r.pt_s2[s_r.port[0]] : bus;
            s_nxt.acc = res;
            s_nxt.zero = (res == 8'h00);
          end
          done = 1'b1;
        end
        cpu_bus_pkg::ST_BRANCH: begin
          s_nxt.pc = s_r.pc + {{8{s_r.imm[7]}}, s_r.imm};
          done = 1'b1;
        end
        cpu_bus_pkg::ST_VEC_LO: begin
          s_nxt.pc[7:0] = bus;
          s_nxt.st = cpu_bus_pkg::ST_VEC_HI;
        end
        cpu_bus_pkg::ST_VEC_HI: begin
          s_nxt.pc[15:8] = bus;
          s_nxt.st = cpu_bus_pkg::ST_FETCH;
        end
        default: done = 1'b1;
      endcase
      // Interrupts are taken only between instructions; enable self-clears
      // so a held request cannot re-enter before software re-enables
      if (done) begin
        if (s_r.int_en && s_r.int_s2) begin
          s_nxt.int_en = 1'b0;
          s_nxt.st = cpu_bus_pkg::ST_VEC_LO;
        end else begin
          s_nxt.st = cpu_bus_pkg::ST_FETCH;
        end
      end
      // Command and our own bus drive are set up for the coming cycle
      s_nxt.cmd = cmd_of(s_nxt.st, s_nxt.is_out);
      s_nxt.dboe = (s_nxt.st == cpu_bus_pkg::ST_IO_ADDR) ||
                   (s_nxt.st == cpu_bus_pkg::ST_BRANCH) ||
                   (s_nxt.st == cpu_bus_pkg::ST_IO_DATA &&
                    s_nxt.is_out);
      unique case (s_nxt.st)
        cpu_bus_pkg::ST_IO_ADDR: s_nxt.dbo = s_nxt.port;
        cpu_bus_pkg::ST_IO_DATA: s_nxt.dbo = s_nxt.acc;
        default: s_nxt.dbo = s_nxt.imm;
      endcase
    end
  end

  // Cycle length for the cycle that starts at this strobe edge
  assign long_next = is_long(s_nxt.st);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{st: cpu_bus_pkg::ST_FETCH, cmd: cpu_bus_pkg::CMD_FETCH,
               pc: cpu_bus_pkg::PC_RESET, acc: cpu_bus_pkg::ACC_RESET,
               latch: {2{cpu_bus_pkg::PORT_RESET}}, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs: a latch bit of 0 pulls the pin low, 1 leaves it to the pull-up
  // so the pin reads the wired-AND of both sides
  assign cycle_command_code = s_r.cmd;
  assign shared_data_lines_o = s_r.dbo;
  assign shared_data_lines_oe = {8{s_r.dboe}};
  assign port_pins.o = '0;
  assign port_pins.oe = ~s_r.latch;
  assign program_counter = s_r.pc;
  assign accumulator = s_r.acc;
  assign zero_flag = s_r.zero;

endmodule

`default_nettype wire

// file: bench/cpu_bus_sequencer_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Timing and drive checks at the sequencer's own ports
module cpu_bus_sequencer_chk (
  input wire logic clock,
  input wire logic resetn,
  input wire logic phi,
  input wire logic write_strobe,
  input wire logic [4:0] cycle_command_code,
  input wire logic [7:0] shared_data_lines_o,
  input wire logic [7:0] shared_data_lines_oe,
  input wire cpu_bus_pkg::port_pins_s port_pins,
  input wire logic [15:0] program_counter,
  input wire logic [7:0] accumulator,
  input wire logic zero_flag
);
  logic ws_d_r;
  logic seen_r;
  logic [9:0] cyc_r;
  logic [7:0] ws_cnt_r;
  logic [6:0] phi_cnt_r;
  logic [4:0] cmd_q_r;
  wire logic fall_now;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  assign fall_now = ws_d_r & ~write_strobe;
  //////////////////////////////////////////////////////////////////////////
  // Counters; the first cycle after reset has no strobe fall before it, so skip it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ws_d_r <= 1'b0;
      seen_r <= 1'b0;
      cyc_r <= 10'h000;
      ws_cnt_r <= 8'h00;
      phi_cnt_r <= 7'h00;
      cmd_q_r <= 5'h00;
    end else begin
      ws_d_r <= write_strobe;
      cyc_r <= fall_now ? 10'h001 : cyc_r + 10'h001;
      ws_cnt_r <= write_strobe ? ws_cnt_r + 8'h01 : 8'h00;
      phi_cnt_r <= phi ? phi_cnt_r + 7'h01 : 7'h00;
      if (write_strobe) cmd_q_r <= cycle_command_code;
      if (fall_now) seen_r <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_oe_all_bits: assert property (
    shared_data_lines_oe inside {8'h00, 8'hFF})
    else $error("Data bus enable bits disagree");
  a_cmd_legal: assert property (
    cycle_command_code inside {[5'h00:5'h08], 5'h1F})
    else $error("Undefined cycle command code");
  a_cmd_held: assert property (
    !$stable(cycle_command_code) |-> $past(write_strobe))
    else $error("Command changed inside a cycle");
  a_phi_high_len: assert property (
    $fell(phi) && seen_r |-> phi_cnt_r == cpu_bus_pkg::PHI_HIGH_CNT)
    else $error("Basic clock high time wrong");
  a_strobe_width: assert property (
    $fell(write_strobe) |-> ws_cnt_r == 8'h7D)
    else $error("Strobe not one basic period wide");
  a_cycle_length: assert property (
    fall_now && seen_r |-> cyc_r ==
      ((cmd_q_r inside {5'h03, 5'h04, 5'h05}) ? 10'h2EE : 10'h1F4))
    else $error("Cycle length wrong for its command");
  a_state_on_strobe: assert property (
    !$stable({program_counter, accumulator, zero_flag, port_pins})
      |-> $past(write_strobe))
    else $error("State changed outside the strobe");
  a_drive_select: assert property (
    (shared_data_lines_oe != 8'h00) ==
      (cycle_command_code inside {5'h03, 5'h05, 5'h06}))
    else $error("Bus driven in an unselected cycle");
  a_write_acc: assert property (
    cycle_command_code == 5'h05 |-> shared_data_lines_o == accumulator)
    else $error("Output cycle does not carry the accumulator");
  a_port_pull_low: assert property (
    port_pins.o == 16'h0000)
    else $error("Port pin driven high");
  a_port_on_write: assert property (
    !$stable(port_pins.oe) |-> $past(cycle_command_code) == 5'h05)
    else $error("Port latch changed outside an output cycle");
  c_long_cycle: cover property (fall_now && cyc_r == 10'h2EE);
  c_branch_add: cover property (cycle_command_code == 5'h06);
  c_vector: cover property (cycle_command_code == 5'h08);
endmodule
bind cpu_bus_sequencer cpu_bus_sequencer_chk i_chk (
  .clock(clock),
  .resetn(resetn),
  .phi(phi),
  .write_strobe(write_strobe),
  .cycle_command_code(cycle_command_code),
  .shared_data_lines_o(shared_data_lines_o),
  .shared_data_lines_oe(shared_data_lines_oe),
  .port_pins(port_pins),
  .program_counter(program_counter),
  .accumulator(accumulator),
  .zero_flag(zero_flag)
);
`default_nettype wire

// file: bench/bus_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
// Program store, fixed memory-read data (11) and far I/O ports behind the command lines
module bus_partner_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic write_strobe,
  input wire logic [4:0] cycle_command_code,
  input wire logic [7:0] cpu_o,
  input wire logic [7:0] cpu_oe,
  input wire logic slow,
  input wire logic [15:0] vector,
  output logic [7:0] wire_level,
  output logic [7:0] last_port,
  output logic [7:0] last_data
);
  logic [7:0] mem [0:255];
  logic [15:0] pc_r;
  logic [7:0] io_port_r, cap_r, prev_r, drv_data;
  logic [4:0] cmd_r;
  logic [9:0] cnt_r;
  logic ws_d_r, drv;
  //////////////////////////////////////////////////////////////////////////
  // Source data only when the command selects this side; slow mode is late
  always_comb begin
    drv = 1'b1;
    drv_data = 8'h00;
    case (cycle_command_code)
      5'h00, 5'h01: drv_data = mem[pc_r[7:0]];
      5'h02: drv_data = 8'h11;
      5'h04: begin
        drv = io_port_r >= cpu_bus_pkg::LOCAL_PORTS;
        drv_data = io_port_r ^ 8'h5A;
      end
      5'h07: drv_data = vector[7:0];
      5'h08: drv_data = vector[15:8];
      default: drv = 1'b0;
    endcase
    if (slow && cnt_r < 10'h190) drv_data = ~prev_r;
  end
  // Released wire shows the inverse of its last level, no pull-up assumed
  assign wire_level = (cpu_oe != 8'h00) ? cpu_o
                    : (drv ? drv_data : ~prev_r);
  // Act on each cycle one clock after the strobe has ended it
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pc_r <= 16'h0000;
      ws_d_r <= 1'b0;
      cnt_r <= 10'h000;
      io_port_r <= 8'h00;
      prev_r <= 8'h00;
    end else begin
      ws_d_r <= write_strobe;
      prev_r <= wire_level;
      cnt_r <= cnt_r + 10'h001;
      if (write_strobe) begin
        cmd_r <= cycle_command_code;
        cap_r <= wire_level;
      end
      if (ws_d_r && !write_strobe) begin
        cnt_r <= 10'h001;
        case (cmd_r)
          5'h00, 5'h01: pc_r <= pc_r + 16'h0001;
          5'h03: io_port_r <= cap_r;
          5'h05: begin
            last_port <= io_port_r;
            last_data <= cap_r;
          end
          5'h06: pc_r <= pc_r + {{8{cap_r[7]}}, cap_r};
          5'h07: pc_r[7:0] <= cap_r;
          5'h08: pc_r[15:8] <= cap_r;
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/test_cpu_system_bus_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_system_bus_sequencer;
  localparam logic [191:0] PROG =
    192'h57AA53AA5A0257005B0575593C70025400126458C3618100;
  logic clock = 1'b0;
  logic resetn, int_req_n, slow, phi, write_strobe, zero_flag;
  logic [1:0][7:0] port_i;
  logic [4:0] cycle_command_code;
  logic [7:0] bus_o, bus_oe, bus_wire, last_port, last_data, accumulator;
  logic [15:0] program_counter;
  cpu_bus_pkg::port_pins_s port_pins;
  int num_errors = 0;
  int n_checks = 0;
  always #2 clock = ~clock;
  cpu_bus_sequencer i_dut (
    .clock(clock),
    .resetn(resetn),
    .phi(phi),
    .write_strobe(write_strobe),
    .cycle_command_code(cycle_command_code),
    .shared_data_lines_i(bus_wire),
    .shared_data_lines_o(bus_o),
    .shared_data_lines_oe(bus_oe),
    .int_req_n(int_req_n),
    .port_i(port_i),
    .port_pins(port_pins),
    .program_counter(program_counter),
    .accumulator(accumulator),
    .zero_flag(zero_flag)
  );
  bus_partner_model i_mem (
    .clock(clock),
    .resetn(resetn),
    .write_strobe(write_strobe),
    .cycle_command_code(cycle_command_code),
    .cpu_o(bus_o),
    .cpu_oe(bus_oe),
    .slow(slow),
    .vector(16'h0040),
    .wire_level(bus_wire),
    .last_port(last_port),
    .last_data(last_data)
  );
  //////////////////////////////////////////////////////////////////////////
  // One compare for every value, widened to 16 bits
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded wait for the mirrored program counter, at falling edges
  task automatic wait_pc(input logic [15:0] a);
    int n = 0;
    while (program_counter !== a && n < 20000) begin
      @(negedge clock);
      n++;
    end
    if (n >= 20000) check(program_counter, a);
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    int n = 0;
    check({11'h000, cycle_command_code}, 16'h0000);
    check({8'h00, bus_oe}, 16'h0000);
    check(port_pins.oe, 16'h0000);
    check({15'h0000, phi}, 16'h0001);
    @(negedge clock);
    resetn = 1'b1;
    do begin
      @(negedge clock);
      n++;
    end while (!write_strobe && n < 2000);
    check(16'(n), 16'h0177);
    $display("test reset done");
  endtask
  task automatic t_alu();
    wait_pc(16'h0003);
    check({8'h00, accumulator}, 16'h00AA);
    wait_pc(16'h0005);
    check({15'h0000, zero_flag}, 16'h0001);
    check({8'h00, accumulator}, 16'h00AA);
    wait_pc(16'h000B);
    check({8'h00, accumulator}, 16'h00AA);
    $display("test alu and branch done");
  endtask
  task automatic t_out();
    wait_pc(16'h000C);
    check({last_port, last_data}, 16'h05AA);
    wait_pc(16'h000E);
    check({last_port, last_data}, 16'h3CAA);
    wait_pc(16'h000F);
    check(port_pins.oe, 16'h0055);
    $display("test output done");
  endtask
  task automatic t_in_slow();
    slow = 1'b1;
    wait_pc(16'h0012);
    check({8'h00, accumulator}, 16'h00BB);
    wait_pc(16'h0013);
    check({8'h00, accumulator}, 16'h00AA);
    slow = 1'b0;
    wait_pc(16'h0014);
    check({8'h00, accumulator}, 16'h005E);
    wait_pc(16'h0016);
    check({8'h00, accumulator}, 16'h0099);
    wait_pc(16'h0017);
    check({8'h00, accumulator}, 16'h003C);
    $display("test input done");
  endtask
  task automatic t_irq();
    wait_pc(16'h0018);
    // Sole requester, and the 81 at 0016 has enabled interrupts, so it is granted
    int_req_n = 1'b0;
    wait_pc(16'h0040);
    check({11'h000, cycle_command_code}, 16'h0008);
    int_req_n = 1'b1;
    wait_pc(16'h0043);
    check({8'h00, accumulator}, 16'h0077);
    wait_pc(16'h0045);
    check({8'h00, accumulator}, 16'h001D);
    $display("test interrupt done");
  endtask
  task automatic t_mid_reset();
    resetn = 1'b0;
    repeat (5) @(negedge clock);
    check(program_counter, 16'h0000);
    resetn = 1'b1;
    wait_pc(16'h0003);
    check({8'h00, accumulator}, 16'h00AA);
    $display("test second reset done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence: load the program store, hold reset, run the scenarios
  initial begin
    resetn = 1'b0;
    int_req_n = 1'b1;
    slow = 1'b0;
    port_i = {8'h3C, 8'hFF};
    for (int i = 0; i < 256; i++) i_mem.mem[i] = 8'h00;
    for (int i = 0; i < 24; i++) i_mem.mem[i] = PROG[191-8*i -: 8];
    i_mem.mem[8'h40] = 8'h57;
    i_mem.mem[8'h41] = 8'h77;
    i_mem.mem[8'h42] = 8'h22;
    i_mem.mem[8'h43] = 8'h40;
    i_mem.mem[8'h44] = 8'h5B;
    i_mem.mem[8'h45] = 8'hFE;
    repeat (20) @(negedge clock);
    t_reset();
    t_alu();
    t_out();
    t_in_slow();
    t_irq();
    t_mid_reset();
    report_and_stop();
  end
  // Watchdog well beyond the expected run of about 30000 clocks
  initial begin
    repeat (90000) @(posedge clock);
    num_errors++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
